// [hdl/cdbu_pkg.sv]
package cdbu_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_THREADS = 8;
  localparam int NUM_BRK = 4;
  localparam int NUM_SCRATCH = 8;
  localparam int STAT_WIDTH = 11;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_SAVED_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SAVED_PC = 8'h11;
  localparam logic [7:0] ADDR_SAVED_SP = 8'h12;
  localparam logic [7:0] ADDR_READ_THREAD_SEL = 8'h13;
  localparam logic [7:0] ADDR_READ_REG_SEL = 8'h14;
  localparam logic [7:0] ADDR_INT_CAUSE = 8'h15;
  localparam logic [7:0] ADDR_INT_INFO = 8'h16;
  localparam logic [7:0] ADDR_STOP_MASK = 8'h18;
  localparam logic [7:0] ADDR_SCRATCH_BASE = 8'h20;
  localparam logic [7:0] ADDR_IBRK_ADDR_BASE = 8'h30;
  localparam logic [7:0] ADDR_IBRK_CTL_BASE = 8'h40;

  // ==========================================================================
  // field layouts
  // status copy: bit 5 reserved, bit 8 (issue mode) captured but read-only
  localparam logic [10:0] STAT_CAPTURE_MASK = 11'h7DF;
  localparam logic [10:0] STAT_WRITE_MASK = 11'h6DF;
  localparam int IBRK_EN_BIT = 0;
  localparam int IBRK_NE_BIT = 1;
  localparam int IBRK_THREAD_LSB = 16;
  localparam int CAUSE_THREAD_LSB = 8;
  localparam int CAUSE_IDX_LSB = 16;

  // ==========================================================================
  // reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [10:0] STAT_RESET = 11'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] REG_SEL_RESET = 5'h00;
  localparam logic [1:0] IDX_RESET = 2'h0;

  // ==========================================================================
  // debug interrupt causes
  typedef enum logic [2:0] {
    CAUSE_NONE    = 3'b000,
    CAUSE_HOST    = 3'b001,
    CAUSE_CALL    = 3'b010,
    CAUSE_IBRK    = 3'b011,
    CAUSE_DATA_WP = 3'b100,
    CAUSE_RES_WP  = 3'b101
  } cdbu_cause_e;

  // lowest set bit of a four-way hit vector
  function automatic logic [1:0] cdbu_lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h3;
    if (v[2]) r = 2'h2;
    if (v[1]) r = 2'h1;
    if (v[0]) r = 2'h0;
    return r;
  endfunction

endpackage

// [hdl/cdbu_ibrk_match.sv]
`timescale 1ns/100ps
module cdbu_ibrk_match (
  input wire logic pc_valid,                     // pc sample valid
  input wire logic [2:0] pc_thread,              // thread of pc sample
  input wire logic [31:0] pc_value,              // program counter
  input wire logic [3:0][31:0] brk_addr,         // breakpoint addresses
  input wire logic [3:0] brk_en,                 // breakpoint enables
  input wire logic [3:0] brk_ne,                 // not-equal condition
  input wire logic [3:0][7:0] brk_thread_en,     // per-thread enables
  output logic hit,                              // any breakpoint fires
  output logic [1:0] hit_idx                     // lowest firing index
);

  logic [3:0] brk_hit;

  // ==========================================================================
  // per-breakpoint compare
  generate
    for (genvar i = 0; i < cdbu_pkg::NUM_BRK; i++) begin : g_cmp
      logic addr_eq;
      assign addr_eq = (pc_value == brk_addr[i]); // [RULE17]
      assign brk_hit[i] = pc_valid & brk_en[i] // [RULE20]
                        & brk_thread_en[i][pc_thread] // [RULE18]
                        & (addr_eq ^ brk_ne[i]); // [RULE19]
    end
  endgenerate

  assign hit = |brk_hit;
  assign hit_idx = cdbu_pkg::cdbu_lowest(brk_hit); // [RULE10]

endmodule

// [hdl/cdbu_core.sv]
// How it works
// [RULE1] capture saved status word on debug entry
// [RULE2] capture saved program counter, software rewritable
// [RULE3] capture saved stack pointer, software rewritable
// [RULE4] status copy keeps the seven thread flags
// [RULE5] asid, kernel issue writable; issue mode read-only
// [RULE6] software sets target thread before register read
// [RULE7] software sets register number before register read
// [RULE8] record cause code, reset to zero
// [RULE9] record breakpoint index, zero for host/call
// [RULE10] simultaneous hits report lowest index
// [RULE11] record triggering thread, zero for host
// [RULE12] data watchpoint stores effective address
// [RULE13] resource watchpoint stores resource identifier
// [RULE14] masked threads stay stopped outside debug
// [RULE15] masked threads stay halted after debug return
// [RULE16] eight scratch words shared with tile config
// [RULE17] four breakpoints compare pc against address
// [RULE18] per-thread enable byte, reset zero
// [RULE19] control bit 1 selects equal or differ
// [RULE20] disabled breakpoint never fires
// [RULE21] cause, thread, index, data updated together
`timescale 1ns/100ps
module cdbu_core (
  input wire logic core_clk,                   // core clock, 250 MHz
  input wire logic rst,                        // async reset, active high
  input wire logic ps_wr_en,                   // status register write
  input wire logic ps_rd_en,                   // status register read
  input wire logic [7:0] ps_addr,              // status register number
  input wire logic [31:0] ps_wdata,            // write data
  output logic [31:0] ps_rdata,                // read data, next cycle
  output logic ps_rd_valid,                    // read data valid pulse
  input wire logic cfg_wr_en,                  // tile config scratch write
  input wire logic cfg_rd_en,                  // tile config scratch read
  input wire logic [2:0] cfg_index,            // scratch word index
  input wire logic [31:0] cfg_wdata,           // config write data
  output logic [31:0] cfg_rdata,               // config read data
  output logic cfg_rd_valid,                   // config read valid pulse
  input wire logic host_req,                   // host debug request
  input wire logic call_req,                   // debug call executed
  input wire logic [2:0] call_thread,          // thread of debug call
  input wire logic pc_valid,                   // pc sample valid
  input wire logic [2:0] pc_thread,            // thread issuing pc
  input wire logic [31:0] pc_value,            // issuing pc
  input wire logic [3:0] data_wp_hit,          // data watchpoint hits
  input wire logic [31:0] data_wp_addr,        // effective address
  input wire logic [3:0] res_wp_hit,           // resource watchpoint hits
  input wire logic [31:0] res_wp_id,           // resource identifier
  input wire logic [2:0] wp_thread,            // thread of watchpoint
  input wire logic [10:0] cur_status,          // live status word
  input wire logic [31:0] cur_pc,              // live resume pc
  input wire logic [31:0] cur_sp,              // live stack pointer
  input wire logic debug_return,               // return from debug pulse
  output logic debug_entry,                    // entry taken pulse
  output logic debug_mode,                     // in debug mode
  output logic [7:0] thread_stop,              // threads held stopped
  output logic [7:0] read_thread_sel,          // register-read thread
  output logic [4:0] read_reg_sel,             // register-read number
  output logic [10:0] return_status,           // status restored on return
  output logic [31:0] return_pc,               // pc restored on return
  output logic [31:0] return_sp                // sp restored on return
);

  // ==========================================================================
  // state
  logic [10:0] saved_status;
  logic [31:0] saved_pc, saved_sp, int_info;
  logic [7:0] thread_sel, cause_thread, stop_mask;
  logic [4:0] reg_sel;
  cdbu_pkg::cdbu_cause_e cause;
  logic [1:0] cause_idx;
  logic [31:0] scratch [cdbu_pkg::NUM_SCRATCH];
  logic [3:0][31:0] brk_addr;
  logic [3:0] brk_en, brk_ne;
  logic [3:0][7:0] brk_thread_en;

  // ==========================================================================
  // breakpoint compare and entry arbitration
  logic ibrk_hit, take, dwp_any, rwp_any;
  logic [1:0] ibrk_idx, next_idx;
  cdbu_pkg::cdbu_cause_e next_cause;
  logic [7:0] next_thread;
  logic [31:0] next_info;

  cdbu_ibrk_match u_match (
    .pc_valid(pc_valid),
    .pc_thread(pc_thread),
    .pc_value(pc_value),
    .brk_addr(brk_addr),
    .brk_en(brk_en),
    .brk_ne(brk_ne),
    .brk_thread_en(brk_thread_en),
    .hit(ibrk_hit),
    .hit_idx(ibrk_idx)
  );
  assign dwp_any = |data_wp_hit;
  assign rwp_any = |res_wp_hit;
  // no nesting: a second event while in debug is dropped
  assign take = ~debug_mode
              & (host_req | call_req | ibrk_hit | dwp_any | rwp_any);

  // fixed priority: host, call, instruction, data, resource
  assign next_cause = host_req  ? cdbu_pkg::CAUSE_HOST :
                      call_req  ? cdbu_pkg::CAUSE_CALL :
                      ibrk_hit  ? cdbu_pkg::CAUSE_IBRK :
                      dwp_any   ? cdbu_pkg::CAUSE_DATA_WP :
                                  cdbu_pkg::CAUSE_RES_WP; // [RULE8]
  assign next_idx = (host_req | call_req) ? cdbu_pkg::IDX_RESET : // [RULE9]
                    ibrk_hit ? ibrk_idx :
                    dwp_any  ? cdbu_pkg::cdbu_lowest(data_wp_hit) :
                               cdbu_pkg::cdbu_lowest(res_wp_hit); // [RULE10]
  assign next_thread = host_req  ? cdbu_pkg::BYTE_RESET : // [RULE11]
                       call_req  ? {5'h00, call_thread} :
                       ibrk_hit  ? {5'h00, pc_thread} :
                                   {5'h00, wp_thread};
  assign next_info = (host_req | call_req | ibrk_hit) ? cdbu_pkg::WORD_RESET :
                     dwp_any ? data_wp_addr : // [RULE12]
                               res_wp_id; // [RULE13]

  // ==========================================================================
  // register decode
  logic wr, sel_scratch, sel_ibrk_addr, sel_ibrk_ctl;
  logic [2:0] sub8;
  logic [1:0] sub4;

  // writes are debug-only, so they never collide with a capture
  assign wr = ps_wr_en & debug_mode;
  assign sub8 = ps_addr[2:0];
  assign sub4 = ps_addr[1:0];
  assign sel_scratch = (ps_addr[7:3] == cdbu_pkg::ADDR_SCRATCH_BASE[7:3]);
  assign sel_ibrk_addr = (ps_addr[7:2] == cdbu_pkg::ADDR_IBRK_ADDR_BASE[7:2]);
  assign sel_ibrk_ctl = (ps_addr[7:2] == cdbu_pkg::ADDR_IBRK_CTL_BASE[7:2]);

  // ==========================================================================
  // entry capture and debug mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      debug_mode <= 1'b0;
      debug_entry <= 1'b0;
    end else begin
      debug_entry <= take;
      if (take)
        debug_mode <= 1'b1;
      else if (debug_return)
        debug_mode <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      saved_status <= cdbu_pkg::STAT_RESET;
    end else if (take) begin
      saved_status <= cur_status & cdbu_pkg::STAT_CAPTURE_MASK; // [RULE1]
    end else if (wr && ps_addr == cdbu_pkg::ADDR_SAVED_STATUS) begin
      saved_status <= (ps_wdata[10:0] & cdbu_pkg::STAT_WRITE_MASK) // [RULE4]
                    | (saved_status & ~cdbu_pkg::STAT_WRITE_MASK); // [RULE5]
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      saved_pc <= cdbu_pkg::WORD_RESET;
      saved_sp <= cdbu_pkg::WORD_RESET;
    end else if (take) begin
      saved_pc <= cur_pc; // [RULE2]
      saved_sp <= cur_sp; // [RULE3]
    end else begin
      if (wr && ps_addr == cdbu_pkg::ADDR_SAVED_PC)
        saved_pc <= ps_wdata; // [RULE2]
      if (wr && ps_addr == cdbu_pkg::ADDR_SAVED_SP)
        saved_sp <= ps_wdata; // [RULE3]
    end
  end
  // on entry all four fields change in one edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cause <= cdbu_pkg::CAUSE_NONE; // [RULE8]
      cause_thread <= cdbu_pkg::BYTE_RESET;
      cause_idx <= cdbu_pkg::IDX_RESET;
      int_info <= cdbu_pkg::WORD_RESET;
    end else if (take) begin
      cause <= next_cause; // [RULE21]
      cause_thread <= next_thread;
      cause_idx <= next_idx;
      int_info <= next_info;
    end else begin
      if (wr && ps_addr == cdbu_pkg::ADDR_INT_CAUSE) begin
        cause <= cdbu_pkg::cdbu_cause_e'(ps_wdata[2:0]);
        cause_thread <= ps_wdata[15:8];
        cause_idx <= ps_wdata[17:16];
      end
      if (wr && ps_addr == cdbu_pkg::ADDR_INT_INFO)
        int_info <= ps_wdata;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thread_sel <= cdbu_pkg::BYTE_RESET;
      reg_sel <= cdbu_pkg::REG_SEL_RESET;
      stop_mask <= cdbu_pkg::BYTE_RESET;
    end else if (wr) begin
      if (ps_addr == cdbu_pkg::ADDR_READ_THREAD_SEL)
        thread_sel <= ps_wdata[7:0]; // [RULE6]
      if (ps_addr == cdbu_pkg::ADDR_READ_REG_SEL)
        reg_sel <= ps_wdata[4:0]; // [RULE7]
      if (ps_addr == cdbu_pkg::ADDR_STOP_MASK)
        stop_mask <= ps_wdata[7:0];
    end
  end

  // ==========================================================================
  // scratch words and breakpoint registers
  generate
    for (genvar i = 0; i < cdbu_pkg::NUM_SCRATCH; i++) begin : g_scr
      // processor port wins a same-cycle clash with the config port
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
          scratch[i] <= cdbu_pkg::WORD_RESET;
        else if (wr && sel_scratch && sub8 == 3'(i))
          scratch[i] <= ps_wdata; // [RULE16]
        else if (cfg_wr_en && cfg_index == 3'(i))
          scratch[i] <= cfg_wdata; // [RULE16]
      end
    end
    for (genvar i = 0; i < cdbu_pkg::NUM_BRK; i++) begin : g_brk
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          brk_addr[i] <= cdbu_pkg::WORD_RESET;
          brk_en[i] <= 1'b0; // [RULE20]
          brk_ne[i] <= 1'b0;
          brk_thread_en[i] <= cdbu_pkg::BYTE_RESET; // [RULE18]
        end else if (wr && sel_ibrk_addr && sub4 == 2'(i)) begin
          brk_addr[i] <= ps_wdata; // [RULE17]
        end else if (wr && sel_ibrk_ctl && sub4 == 2'(i)) begin
          brk_en[i] <= ps_wdata[cdbu_pkg::IBRK_EN_BIT];
          brk_ne[i] <= ps_wdata[cdbu_pkg::IBRK_NE_BIT]; // [RULE19]
          brk_thread_en[i] <= ps_wdata[cdbu_pkg::IBRK_THREAD_LSB +: 8];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read path
  logic [31:0] rd_mux, ctl_word, cause_word;

  assign ctl_word = {8'h00, brk_thread_en[sub4], 14'h0000,
                     brk_ne[sub4], brk_en[sub4]};
  assign cause_word = {14'h0000, cause_idx, cause_thread, 5'h00, cause};
  assign rd_mux =
    (ps_addr == cdbu_pkg::ADDR_SAVED_STATUS)    ? {21'h00_0000, saved_status} :
    (ps_addr == cdbu_pkg::ADDR_SAVED_PC)        ? saved_pc :
    (ps_addr == cdbu_pkg::ADDR_SAVED_SP)        ? saved_sp :
    (ps_addr == cdbu_pkg::ADDR_READ_THREAD_SEL) ? {24'h00_0000, thread_sel} :
    (ps_addr == cdbu_pkg::ADDR_READ_REG_SEL)    ? {27'h000_0000, reg_sel} :
    (ps_addr == cdbu_pkg::ADDR_INT_CAUSE)       ? cause_word :
    (ps_addr == cdbu_pkg::ADDR_INT_INFO)        ? int_info :
    (ps_addr == cdbu_pkg::ADDR_STOP_MASK)       ? {24'h00_0000, stop_mask} :
    sel_scratch                                 ? scratch[sub8] :
    sel_ibrk_addr                               ? brk_addr[sub4] :
    sel_ibrk_ctl                                ? ctl_word :
                                                  cdbu_pkg::WORD_RESET;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ps_rdata <= cdbu_pkg::WORD_RESET;
      ps_rd_valid <= 1'b0;
      cfg_rdata <= cdbu_pkg::WORD_RESET;
      cfg_rd_valid <= 1'b0;
    end else begin
      ps_rd_valid <= ps_rd_en;
      cfg_rd_valid <= cfg_rd_en;
      if (ps_rd_en)
        ps_rdata <= rd_mux;
      if (cfg_rd_en)
        cfg_rdata <= scratch[cfg_index]; // [RULE16]
    end
  end

  // ==========================================================================
  // outputs
  // mask only bites outside debug, which also covers the return
  assign thread_stop = debug_mode ? cdbu_pkg::BYTE_RESET
                                  : stop_mask; // [RULE14][RULE15]
  assign read_thread_sel = thread_sel;
  assign read_reg_sel = reg_sel;
  assign return_status = saved_status;
  assign return_pc = saved_pc;
  assign return_sp = saved_sp;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_STATUS_CAPTURE: assert property ( // [RULE1]
    take |=> saved_status == ($past(cur_status) & cdbu_pkg::STAT_CAPTURE_MASK))
    else $error("status copy not captured on entry");
  AST_PC_CAPTURE: assert property ( // [RULE2]
    take |=> saved_pc == $past(cur_pc) ##1 saved_pc == $past(cur_pc, 2)
             || $past(ps_wr_en))
    else $error("saved pc not captured on entry");
  AST_SP_CAPTURE: assert property ( // [RULE3]
    take |=> saved_sp == $past(cur_sp))
    else $error("saved sp not captured on entry");
  AST_ISSUE_BIT_RO: assert property ( // [RULE5]
    (ps_wr_en && ps_addr == cdbu_pkg::ADDR_SAVED_STATUS && !take)
      |=> $stable(saved_status[8]) && !saved_status[5])
    else $error("read-only status bit changed by write");
  AST_HOST_FIELDS: assert property ( // [RULE11]
    (take && host_req) |=> cause == cdbu_pkg::CAUSE_HOST
                           && cause_thread == 8'h00 && cause_idx == 2'h0)
    else $error("host entry fields wrong");
  AST_LOWEST_WP: assert property ( // [RULE10]
    (take && next_cause == cdbu_pkg::CAUSE_DATA_WP
      && data_wp_hit[1:0] == 2'b10) |=> cause_idx == 2'h1)
    else $error("lowest watchpoint not reported");
  AST_DATA_INFO: assert property ( // [RULE12]
    (take && next_cause == cdbu_pkg::CAUSE_DATA_WP)
      |=> int_info == $past(data_wp_addr) && debug_entry)
    else $error("data address not recorded");
  AST_STOP_OUTSIDE: assert property ( // [RULE14]
    !debug_mode |-> (thread_stop & stop_mask) == stop_mask)
    else $error("masked thread allowed to run");
  AST_STOP_RETURN: assert property ( // [RULE15]
    (debug_mode && debug_return) |=> !debug_mode && thread_stop == stop_mask)
    else $error("masked threads released on return");
  AST_BRK_DISABLED: assert property ( // [RULE20]
    (brk_en == 4'h0) |-> !ibrk_hit)
    else $error("disabled breakpoint fired");
  AST_ONE_EVENT: assert property ( // [RULE21]
    take |=> debug_mode && cause != cdbu_pkg::CAUSE_NONE ##1 !debug_entry)
    else $error("entry fields or mode inconsistent");
  COV_HOST: cover property (take && host_req);
  COV_IBRK: cover property (take && ibrk_hit ##[1:50] debug_return);
  COV_DATA_WP: cover property (take && dwp_any && !ibrk_hit);
  COV_CFG_SCRATCH: cover property (cfg_wr_en ##1 ps_rd_en && sel_scratch);

endmodule

// [tb/cdbu_live_model.sv]
`timescale 1ns/100ps
// ==========================================================================
// live thread state seen by the capture logic
module cdbu_live_model (
  input wire logic core_clk,      // core clock
  input wire logic rst,           // async reset, active high
  output logic [10:0] cur_status, // live status word
  output logic [31:0] cur_pc,     // live resume pc
  output logic [31:0] cur_sp      // live stack pointer
);
  // moves on the falling edge so every capture edge sees settled values
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      cur_status <= 11'h5A5;
      cur_pc <= 32'h0001_0000;
      cur_sp <= 32'h0002_0000;
    end else begin
      cur_status <= {cur_status[9:0], cur_status[10] ^ cur_status[8]};
      cur_pc <= cur_pc + 32'h0000_0004;
      cur_sp <= cur_sp - 32'h0000_0008;
    end
  end
endmodule

// [tb/core_debug_breakpoint_unit_test.sv]
`timescale 1ns/100ps
module core_debug_breakpoint_unit_test;
  logic core_clk, rst, ps_wr_en, ps_rd_en, cfg_wr_en, cfg_rd_en;
  logic [31:0] ps_wdata, ps_rdata, cfg_wdata, cfg_rdata, pc_value;
  logic [31:0] data_wp_addr, res_wp_id, cur_pc, cur_sp, return_pc, return_sp;
  logic [7:0] ps_addr, thread_stop, read_thread_sel, m;
  logic [4:0] read_reg_sel;
  logic [3:0] data_wp_hit, res_wp_hit;
  logic [2:0] cfg_index, call_thread, pc_thread, wp_thread;
  logic [10:0] cur_status, return_status, x_st;
  logic host_req, call_req, pc_valid, debug_return, debug_entry, debug_mode;
  logic ps_rd_valid, cfg_rd_valid;
  logic [31:0] ps_q[$], cfg_q[$], x_pc, x_sp, d;
  int error_cnt, n_tests;

  cdbu_core u_dut (.core_clk, .rst, .ps_wr_en, .ps_rd_en, .ps_addr, .ps_wdata,
    .ps_rdata, .ps_rd_valid, .cfg_wr_en, .cfg_rd_en, .cfg_index, .cfg_wdata,
    .cfg_rdata, .cfg_rd_valid, .host_req, .call_req, .call_thread,
    .pc_valid, .pc_thread, .pc_value, .data_wp_hit, .data_wp_addr,
    .res_wp_hit, .res_wp_id, .wp_thread, .cur_status, .cur_pc, .cur_sp,
    .debug_return, .debug_entry, .debug_mode, .thread_stop,
    .read_thread_sel, .read_reg_sel, .return_status, .return_pc,
    .return_sp);
  cdbu_live_model u_live (.core_clk, .rst, .cur_status, .cur_pc, .cur_sp);

  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    ps_wr_en <= 1'b1;
    ps_addr <= a;
    ps_wdata <= v;
    @(posedge core_clk);
    ps_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ps_q.push_back(exp);
    @(posedge core_clk);
    ps_rd_en <= 1'b1;
    ps_addr <= a;
    @(posedge core_clk);
    ps_rd_en <= 1'b0;
  endtask
  task automatic cw(input logic [2:0] i, input logic [31:0] v);
    @(posedge core_clk);
    cfg_wr_en <= 1'b1;
    cfg_index <= i;
    cfg_wdata <= v;
    @(posedge core_clk);
    cfg_wr_en <= 1'b0;
  endtask
  task automatic cr(input logic [2:0] i, input logic [31:0] exp);
    cfg_q.push_back(exp);
    @(posedge core_clk);
    cfg_rd_en <= 1'b1;
    cfg_index <= i;
    @(posedge core_clk);
    cfg_rd_en <= 1'b0;
  endtask
  // caller raises the event at the previous edge; this is the taking edge
  task automatic take();
    @(posedge core_clk);
    x_st = cur_status & 11'h7DF;
    x_pc = cur_pc;
    x_sp = cur_sp;
    host_req <= 1'b0;
    call_req <= 1'b0;
    pc_valid <= 1'b0;
    data_wp_hit <= 4'h0;
    res_wp_hit <= 4'h0;
    @(negedge core_clk);
    chk("debug_entry", {31'h0, debug_entry}, 32'h1);
    chk("stop_in_debug", {24'h0, thread_stop}, 32'h0);
  endtask
  task automatic leave();
    @(posedge core_clk);
    debug_return <= 1'b1;
    @(posedge core_clk);
    debug_return <= 1'b0;
    @(negedge core_clk);
    chk("debug_mode", {31'h0, debug_mode}, 32'h0);
    chk("thread_stop", {24'h0, thread_stop}, {24'h0, m});
  endtask

  // ==========================================================================
  // result watcher: oldest note against each read answer
  always @(negedge core_clk) begin
    if (ps_rd_valid === 1'b1)
      chk("ps_rdata", ps_rdata, ps_q.pop_front());
    if (cfg_rd_valid === 1'b1)
      chk("cfg_rdata", cfg_rdata, cfg_q.pop_front());
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  // ==========================================================================
  // main sequence
  initial begin
    {rst, ps_wr_en, ps_rd_en, cfg_wr_en, cfg_rd_en, host_req} = 6'h20;
    {call_req, pc_valid, debug_return, m} = 11'h000;
    {ps_addr, ps_wdata, cfg_index, cfg_wdata, pc_value} = 107'h0;
    {call_thread, pc_thread, wp_thread, data_wp_hit, res_wp_hit} = 17'h0;
    {data_wp_addr, res_wp_id} = 64'h0;
    void'($urandom(74377));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h15, 32'h0);
    for (int k = 0; k < 4; k++) rd(8'h40 + 8'(k), 32'h0);
    wr(8'h18, 32'h0000_00FF);
    rd(8'h18, 32'h0);
    @(posedge core_clk) host_req <= 1'b1;
    take();
    chk("return_pc", return_pc, x_pc);
    chk("return_sp", return_sp, x_sp);
    chk("return_status", {21'h0, return_status}, {21'h0, x_st});
    rd(8'h10, {21'h0, x_st});
    rd(8'h11, x_pc);
    rd(8'h12, x_sp);
    rd(8'h15, 32'h0000_0001);
    rd(8'h16, 32'h0);
    wr(8'h15, 32'hFFFF_FFFF);
    rd(8'h15, 32'h0003_FF07);
    wr(8'h16, x_pc);
    rd(8'h16, x_pc);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, {21'h0, 11'h6DF | (x_st & 11'h100)});
    d = $urandom;
    wr(8'h11, d);
    wr(8'h12, ~d);
    wr(8'h13, d);
    wr(8'h14, d);
    rd(8'h11, d);
    rd(8'h12, ~d);
    rd(8'h13, d & 32'h0000_00FF);
    rd(8'h14, d & 32'h0000_001F);
    chk("thread_sel", {24'h0, read_thread_sel}, d & 32'h0000_00FF);
    chk("reg_sel", {27'h0, read_reg_sel}, d & 32'h0000_001F);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      wr(8'h20 + 8'(i), d);
      cr(3'(i), d);
      cw(3'(i), ~d);
      rd(8'h20 + 8'(i), ~d);
    end
    m = 8'($urandom);
    wr(8'h18, {24'h0, m});
    rd(8'h18, {24'h0, m});
    // thread 5 enabled on 1 and 2, breakpoint 0 only for thread 3
    d = $urandom & 32'hFFFF_FFFC;
    for (int k = 0; k < 4; k++) wr(8'h30 + 8'(k), d);
    wr(8'h40, 32'h0008_0001);
    wr(8'h41, 32'h0020_0001);
    wr(8'h42, 32'h0020_0001);
    wr(8'h43, 32'h0020_0002);
    rd(8'h43, 32'h0020_0002);
    leave();
    @(posedge core_clk) pc_valid <= 1'b1;
    pc_thread <= 3'h5;
    pc_value <= d;
    take();
    rd(8'h15, 32'h0001_0503);
    wr(8'h41, 32'h0020_0000);
    wr(8'h42, 32'h0);
    wr(8'h43, 32'h0020_0003);
    leave();
    @(posedge core_clk) pc_valid <= 1'b1;
    @(posedge core_clk) pc_value <= d + 32'h0000_0004;
    @(negedge core_clk) chk("no_fire", {31'h0, debug_mode}, 32'h0);
    take();
    rd(8'h15, 32'h0003_0503);
    leave();
    @(posedge core_clk) data_wp_hit <= 4'b0110;
    data_wp_addr <= ~d;
    wp_thread <= 3'h6;
    take();
    rd(8'h15, 32'h0001_0604);
    rd(8'h16, ~d);
    leave();
    @(posedge core_clk) res_wp_hit <= 4'b1000;
    res_wp_id <= d;
    wp_thread <= 3'h1;
    take();
    rd(8'h15, 32'h0003_0105);
    rd(8'h16, d);
    leave();
    @(posedge core_clk) call_req <= 1'b1;
    call_thread <= 3'h7;
    res_wp_hit <= 4'b0001;
    take();
    rd(8'h15, 32'h0000_0702);
    leave();
    repeat (3) @(posedge core_clk);
    chk("pending", 32'(ps_q.size() + cfg_q.size()), 32'h0);
    summarize();
  end
endmodule
